// ==== logic/pewc_regs.vh ====
`ifndef PEWC_REGS_VH
`define PEWC_REGS_VH

// clock period of the controller
`define PEWC_CLK_NS        20

// strobe timing, in nanoseconds
`define PEWC_T_WP_NS       100
`define PEWC_T_WPH_NS      50
`define PEWC_T_ACC_NS      250
`define PEWC_T_GAP_NS      150

// byte load window in microseconds, program time in milliseconds
`define PEWC_T_BLW_US      150
`define PEWC_T_PROG_MS     10

// largest page, in bytes
`define PEWC_PAGE_BYTES    8'h80

// user command codes
`define PEWC_OP_WRITE      2'h0
`define PEWC_OP_READ       2'h1
`define PEWC_OP_LOCK_ON    2'h2
`define PEWC_OP_LOCK_OFF   2'h3

// command sequence addresses and data; set to the part in use
`define PEWC_CMD_ADDR_1    15'h5555
`define PEWC_CMD_ADDR_2    15'h2aaa
`define PEWC_CMD_DATA_1    8'haa
`define PEWC_CMD_DATA_2    8'h55
`define PEWC_CMD_DATA_PROT 8'ha0
`define PEWC_CMD_DATA_UNL1 8'h80
`define PEWC_CMD_DATA_UNL2 8'h20

// sequence lengths
`define PEWC_SEQ_LEN_LOCK  3'h3
`define PEWC_SEQ_LEN_UNL   3'h6

`endif

// ==== logic/pewc_tmr.v ====
// down counter; expired while the count sits at zero
module pewc_tmr (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // control
    input  wire        load_i,
    input  wire [19:0] value_i,
    // status
    output wire        expired_o
);

    reg [19:0] cnt_q;

    // load wins over counting, so a restart is never missed
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= 20'h00000;
        else if (load_i)
            cnt_q <= value_i;
        else if (cnt_q != 20'h00000)
            cnt_q <= cnt_q - 20'h00001;
    end

    assign expired_o = (cnt_q == 20'h00000);

endmodule // pewc_tmr

// ==== logic/pewc_host.v ====
// Notes on behaviour
// - next page byte is presented within 150 us of the previous one
// - page-select lines stay at one page value for every write strobe of a page
// - output gate goes high only while write strobe and chip select are both low
// - command words are bytes on data lines; command addresses use 15 lines
// - protected program cycle carries one to 128 data bytes
// - protected writes start with the exact three-word address sequence
// - completion is seen only when the toggling status bit stops changing
// - polling reads keep one unchanged address throughout
`include "pewc_regs.vh"

module pewc_host #(
    parameter [19:0] BLW_CYC  = (`PEWC_T_BLW_US * 1000) / `PEWC_CLK_NS,
    parameter [19:0] PROG_CYC = (`PEWC_T_PROG_MS * 1000000) / `PEWC_CLK_NS
) (
    // clock and reset
    input  wire        REF_CLK_I,
    input  wire        RESET_N_I,
    // user command port
    input  wire        CMD_VALID_I,
    input  wire [1:0]  CMD_OP_I,
    input  wire [16:0] CMD_ADDR_I,
    input  wire [7:0]  CMD_DATA_I,
    input  wire        CMD_PROT_I,
    input  wire        CMD_LAST_I,
    output wire        CMD_READY_O,
    // user answer port
    output wire [7:0]  RD_DATA_O,
    output wire        RD_VALID_O,
    output wire        DONE_O,
    output wire        TIMEOUT_O,
    output wire        BUSY_O,
    // memory pins
    output wire [16:0] MEM_ADDR_O,
    output wire        MEM_CE_N_O,
    output wire        MEM_OE_N_O,
    output wire        MEM_WE_N_O,
    input  wire [7:0]  MEM_DQ_I,
    output wire [7:0]  MEM_DQ_O,
    output wire        MEM_DQ_OE_O
);

    // cycle counts; least times round up
    localparam integer WP_N  = (`PEWC_T_WP_NS + `PEWC_CLK_NS - 1) / `PEWC_CLK_NS;
    localparam integer WPH_N = (`PEWC_T_WPH_NS + `PEWC_CLK_NS - 1) / `PEWC_CLK_NS;
    localparam integer ACC_N = (`PEWC_T_ACC_NS + `PEWC_CLK_NS - 1) / `PEWC_CLK_NS;
    localparam integer GAP_N = (`PEWC_T_GAP_NS + `PEWC_CLK_NS - 1) / `PEWC_CLK_NS;
    localparam integer WR_END_N = WP_N + WPH_N;
    localparam integer RD_END_N = ACC_N + 1;
    localparam [4:0]   WP_CYC = WP_N[4:0];
    localparam [4:0]   WR_END = WR_END_N[4:0];
    localparam [4:0]   RD_END = RD_END_N[4:0];
    localparam [4:0]   GAP_END = GAP_N[4:0];

    // one-hot states
    localparam [5:0] S_IDLE   = 6'h01;
    localparam [5:0] S_WR     = 6'h02;
    localparam [5:0] S_LOAD   = 6'h04;
    localparam [5:0] S_SETTLE = 6'h08;
    localparam [5:0] S_RD     = 6'h10;
    localparam [5:0] S_GAP    = 6'h20;

    reg  [5:0]  state_q;
    reg  [4:0]  ph_q;
    reg  [2:0]  seq_idx_q;
    reg  [2:0]  seq_end_q;
    reg         seq_act_q;
    reg         seq_unl_q;
    reg         data_pend_q;
    reg         page_mode_q;
    reg         last_q;
    reg  [7:0]  cnt_q;
    reg  [9:0]  page_q;
    reg  [16:0] addr_q;
    reg  [7:0]  data_q;
    reg  [16:0] waddr_q;
    reg  [7:0]  wdata_q;
    reg         poll_q;
    reg         have_prev_q;
    reg         prev6_q;
    reg  [7:0]  rd_data_q;
    reg         rd_valid_q;
    reg         done_q;
    reg         tout_q;
    reg         ce_n_q;
    reg         we_n_q;
    reg         oe_n_q;
    reg         dq_oe_q;
    reg         ce_n_d;
    reg         we_n_d;
    reg         oe_n_d;
    reg         dq_oe_d;
    reg         load_ok;
    wire        win_exp;
    wire        prog_exp;
    wire        win_ld;
    wire        prog_ld;
    wire [22:0] seq_next;

    // command word table: {15-bit address, data byte}
    function [22:0] seq_word;
        input       unl;
        input [2:0] idx;
        begin
            case ({unl, idx})
                4'h0:    seq_word = {`PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_1};
                4'h1:    seq_word = {`PEWC_CMD_ADDR_2, `PEWC_CMD_DATA_2};
                4'h2:    seq_word = {`PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_PROT};
                4'h8:    seq_word = {`PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_1};
                4'h9:    seq_word = {`PEWC_CMD_ADDR_2, `PEWC_CMD_DATA_2};
                4'ha:    seq_word = {`PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_UNL1};
                4'hb:    seq_word = {`PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_1};
                4'hc:    seq_word = {`PEWC_CMD_ADDR_2, `PEWC_CMD_DATA_2};
                4'hd:    seq_word = {`PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_UNL2};
                default: seq_word = {`PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_1};
            endcase
        end
    endfunction

    assign seq_next = seq_word(seq_unl_q, seq_idx_q + 3'h1);

    // window restarts at every write strobe; program timer when polling starts
    assign win_ld  = (state_q == S_WR) && (ph_q == 5'h00);
    assign prog_ld = (state_q == S_SETTLE) && win_exp;

    pewc_tmr u_win (
        .clk_i     (REF_CLK_I),
        .rst_n_i   (RESET_N_I),
        .load_i    (win_ld),
        .value_i   (BLW_CYC),
        .expired_o (win_exp)
    );

    pewc_tmr u_prog (
        .clk_i     (REF_CLK_I),
        .rst_n_i   (RESET_N_I),
        .load_i    (prog_ld),
        .value_i   (PROG_CYC),
        .expired_o (prog_exp)
    );

    // a further page byte only if same page, unprotected, window open and room left
    always @*
    begin
        load_ok = CMD_VALID_I && (CMD_OP_I == `PEWC_OP_WRITE) && !CMD_PROT_I
                  && (CMD_ADDR_I[16:7] == page_q)
                  && !win_exp
                  && (cnt_q < `PEWC_PAGE_BYTES);
    end

    assign CMD_READY_O = (state_q == S_IDLE) || ((state_q == S_LOAD) && load_ok);

    // strobe decode; registered below so the pins never glitch
    always @*
    begin
        ce_n_d  = 1'b1;
        we_n_d  = 1'b1;
        oe_n_d  = 1'b0;
        dq_oe_d = 1'b0;
        case (state_q)
            S_WR:
            begin
                // both strobes fall and rise together
                ce_n_d  = !(ph_q < WP_CYC);
                we_n_d  = !(ph_q < WP_CYC);
                // gate high strictly inside the low strobes
                oe_n_d  = (ph_q >= 5'h01) && (ph_q < WP_CYC - 5'h01);
                dq_oe_d = (ph_q <= WP_CYC);
            end
            S_RD:
            begin
                // chip select frames each read so the device steps
                ce_n_d  = (ph_q == RD_END);
            end
            default:
            begin
                ce_n_d  = 1'b1;
            end
        endcase
    end

    always @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            ce_n_q  <= 1'b1;
            we_n_q  <= 1'b1;
            oe_n_q  <= 1'b0;
            dq_oe_q <= 1'b0;
        end
        else
        begin
            ce_n_q  <= ce_n_d;
            we_n_q  <= we_n_d;
            oe_n_q  <= oe_n_d;
            dq_oe_q <= dq_oe_d;
        end
    end

    // main sequencer
    always @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            state_q     <= S_IDLE;
            ph_q        <= 5'h00;
            seq_idx_q   <= 3'h0;
            seq_end_q   <= 3'h0;
            seq_act_q   <= 1'b0;
            seq_unl_q   <= 1'b0;
            data_pend_q <= 1'b0;
            page_mode_q <= 1'b0;
            last_q      <= 1'b0;
            cnt_q       <= 8'h00;
            page_q      <= 10'h000;
            addr_q      <= 17'h00000;
            data_q      <= 8'h00;
            waddr_q     <= 17'h00000;
            wdata_q     <= 8'h00;
            poll_q      <= 1'b0;
            have_prev_q <= 1'b0;
            prev6_q     <= 1'b0;
            rd_data_q   <= 8'h00;
            rd_valid_q  <= 1'b0;
            done_q      <= 1'b0;
            tout_q      <= 1'b0;
        end
        else
        begin
            rd_valid_q <= 1'b0;
            done_q     <= 1'b0;
            tout_q     <= 1'b0;
            ph_q       <= ph_q + 5'h01;
            case (state_q)
                S_IDLE:
                begin
                    ph_q        <= 5'h00;
                    seq_idx_q   <= 3'h0;
                    seq_unl_q   <= (CMD_OP_I == `PEWC_OP_LOCK_OFF);
                    page_q      <= CMD_ADDR_I[16:7];
                    waddr_q     <= CMD_ADDR_I;
                    wdata_q     <= CMD_DATA_I;
                    last_q      <= CMD_LAST_I;
                    poll_q      <= 1'b0;
                    if (CMD_VALID_I)
                    begin
                        case (CMD_OP_I)
                            `PEWC_OP_WRITE:
                            begin
                                state_q     <= S_WR;
                                page_mode_q <= 1'b1;
                                cnt_q       <= 8'h01;
                                seq_act_q   <= CMD_PROT_I;
                                seq_end_q   <= `PEWC_SEQ_LEN_LOCK;
                                data_pend_q <= CMD_PROT_I;
                                if (CMD_PROT_I)
                                begin
                                    // three command words lead the data
                                    addr_q <= {2'b00, `PEWC_CMD_ADDR_1};
                                    data_q <= `PEWC_CMD_DATA_1;
                                end
                                else
                                begin
                                    addr_q <= CMD_ADDR_I;
                                    data_q <= CMD_DATA_I;
                                end
                            end
                            `PEWC_OP_READ:
                            begin
                                state_q <= S_RD;
                                addr_q  <= CMD_ADDR_I;
                            end
                            default:
                            begin
                                // lock on / lock off: sequence only, then program time
                                state_q     <= S_WR;
                                page_mode_q <= 1'b0;
                                data_pend_q <= 1'b0;
                                seq_act_q   <= 1'b1;
                                seq_end_q   <= (CMD_OP_I == `PEWC_OP_LOCK_OFF) ?
                                               `PEWC_SEQ_LEN_UNL : `PEWC_SEQ_LEN_LOCK;
                                addr_q      <= {2'b00, `PEWC_CMD_ADDR_1};
                                data_q      <= `PEWC_CMD_DATA_1;
                            end
                        endcase
                    end
                end
                S_WR:
                begin
                    if (ph_q == WR_END)
                    begin
                        ph_q <= 5'h00;
                        if (seq_act_q && (seq_idx_q + 3'h1 < seq_end_q))
                        begin
                            seq_idx_q <= seq_idx_q + 3'h1;
                            addr_q    <= {2'b00, seq_next[22:8]};
                            data_q    <= seq_next[7:0];
                        end
                        else if (data_pend_q)
                        begin
                            seq_act_q   <= 1'b0;
                            data_pend_q <= 1'b0;
                            addr_q      <= waddr_q;
                            data_q      <= wdata_q;
                        end
                        else
                        begin
                            seq_act_q <= 1'b0;
                            // lock commands go straight to program time
                            if (page_mode_q && !last_q && (cnt_q < `PEWC_PAGE_BYTES))
                                state_q <= S_LOAD;
                            else
                                state_q <= S_SETTLE;
                        end
                    end
                end
                S_LOAD:
                begin
                    ph_q <= 5'h00;
                    if (load_ok)
                    begin
                        state_q <= S_WR;
                        addr_q  <= CMD_ADDR_I;
                        data_q  <= CMD_DATA_I;
                        last_q  <= CMD_LAST_I;
                        cnt_q   <= cnt_q + 8'h01;
                    end
                    else if (win_exp || CMD_VALID_I)
                        state_q <= S_SETTLE;
                end
                S_SETTLE:
                begin
                    // let the window lapse so the device surely starts programming
                    ph_q <= 5'h00;
                    if (win_exp)
                    begin
                        state_q     <= S_RD;
                        poll_q      <= 1'b1;
                        have_prev_q <= 1'b0;
                    end
                end
                S_RD:
                begin
                    if (ph_q == RD_END)
                    begin
                        ph_q      <= 5'h00;
                        state_q   <= S_GAP;
                        rd_data_q <= MEM_DQ_I;
                        prev6_q   <= MEM_DQ_I[6];
                        have_prev_q <= 1'b1;
                        if (!poll_q)
                            rd_valid_q <= 1'b1;
                        else if (have_prev_q && (prev6_q == MEM_DQ_I[6]))
                        begin
                            // no start value assumed; only a steady bit counts
                            done_q <= 1'b1;
                            poll_q <= 1'b0;
                        end
                        else if (prog_exp)
                        begin
                            // still toggling past program time
                            tout_q <= 1'b1;
                            poll_q <= 1'b0;
                        end
                    end
                end
                S_GAP:
                begin
                    if (ph_q == GAP_END)
                    begin
                        ph_q <= 5'h00;
                        // addr_q untouched, every poll hits one location
                        state_q <= poll_q ? S_RD : S_IDLE;
                    end
                end
                default:
                begin
                    state_q <= S_IDLE;
                    ph_q    <= 5'h00;
                end
            endcase
        end
    end

    assign RD_DATA_O   = rd_data_q;
    assign RD_VALID_O  = rd_valid_q;
    assign DONE_O      = done_q;
    assign TIMEOUT_O   = tout_q;
    assign BUSY_O      = (state_q != S_IDLE);
    assign MEM_ADDR_O  = addr_q;
    assign MEM_CE_N_O  = ce_n_q;
    assign MEM_OE_N_O  = oe_n_q;
    assign MEM_WE_N_O  = we_n_q;
    assign MEM_DQ_O    = data_q;
    assign MEM_DQ_OE_O = dq_oe_q;

endmodule // pewc_host

// ==== bench/pewc_host_sva.sv ====
`include "pewc_regs.vh"

// pin-level checks on the host controller
module pewc_host_sva #(
    parameter [19:0] BLW_CYC  = 20'd7500,
    parameter [19:0] PROG_CYC = 20'd500000
) (
    // clock and reset
    input wire        REF_CLK_I,
    input wire        RESET_N_I,
    // user side
    input wire        CMD_VALID_I,
    input wire [1:0]  CMD_OP_I,
    input wire        CMD_READY_O,
    input wire        RD_VALID_O,
    input wire        DONE_O,
    input wire        TIMEOUT_O,
    input wire        BUSY_O,
    // memory pins
    input wire [16:0] MEM_ADDR_O,
    input wire        MEM_CE_N_O,
    input wire        MEM_OE_N_O,
    input wire        MEM_WE_N_O,
    input wire [7:0]  MEM_DQ_O,
    input wire        MEM_DQ_OE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    // strobe edges and read frames as seen on the pins
    logic        we_q, load_q, pg_ok_q, poll_q;
    logic [9:0]  pg_q;
    logic [16:0] wa_q;
    logic [19:0] gap_q;
    wire         fall_w = !MEM_WE_N_O && we_q;
    wire         rd_w   = !MEM_CE_N_O && MEM_WE_N_O;
    wire         cmd_w  = (MEM_ADDR_O[14:0] == `PEWC_CMD_ADDR_1)
                        || (MEM_ADDR_O[14:0] == `PEWC_CMD_ADDR_2);

    // a read closes the page load; done or timeout closes polling
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            {we_q, load_q, pg_ok_q, poll_q} <= 4'h8;
            {pg_q, wa_q, gap_q} <= '0;
        end
        else
        begin
            we_q    <= MEM_WE_N_O;
            gap_q   <= MEM_WE_N_O ? gap_q + 20'h1 : 20'h0;
            load_q  <= rd_w ? 1'b0 : (fall_w | load_q);
            poll_q  <= (DONE_O | TIMEOUT_O) ? 1'b0 : (fall_w | poll_q);
            pg_ok_q <= rd_w ? 1'b0 : ((fall_w && !cmd_w) | pg_ok_q);
            if (fall_w)
                wa_q <= MEM_ADDR_O;
            if (fall_w && !cmd_w)
                pg_q <= MEM_ADDR_O[16:7];
        end
    end

    a_oe_in_strobe: assert property (MEM_OE_N_O |-> !MEM_WE_N_O && !MEM_CE_N_O)
        else $error("output gate high outside the write strobe");
    a_page_same: assert property (fall_w && pg_ok_q && !cmd_w |-> MEM_ADDR_O[16:7] == pg_q)
        else $error("page lines changed inside a page load");
    a_poll_addr: assert property (poll_q && rd_w |-> MEM_ADDR_O == wa_q)
        else $error("polling address moved");
    a_byte_gap: assert property (fall_w && load_q |-> gap_q <= BLW_CYC)
        else $error("byte load window missed");
    a_strobe_hold: assert property (!MEM_WE_N_O && !we_q |-> $stable(MEM_ADDR_O)
        && $stable(MEM_DQ_O) && MEM_DQ_OE_O && !MEM_CE_N_O)
        else $error("address or data moved under the strobe");
    a_strobe_width: assert property (fall_w |-> !MEM_WE_N_O [*5] ##1 MEM_WE_N_O)
        else $error("write pulse not five cycles");
    a_we_high_min: assert property ($rose(MEM_WE_N_O) |-> MEM_WE_N_O [*3])
        else $error("write strobe high time too short");
    a_ce_gap_min: assert property ($rose(MEM_CE_N_O) |-> MEM_CE_N_O [*3])
        else $error("chip select high time too short");
    a_no_fight: assert property (MEM_DQ_OE_O |-> !(rd_w && !MEM_OE_N_O))
        else $error("host drives data during a read");
    a_rd_answer: assert property (CMD_VALID_I && CMD_READY_O && !BUSY_O
        && CMD_OP_I == `PEWC_OP_READ |-> ##16 RD_VALID_O)
        else $error("read answer late or missing");

    c_page: cover property (fall_w && load_q);
    c_poll_end: cover property (poll_q && DONE_O);
    c_read: cover property (RD_VALID_O);
endmodule // pewc_host_sva

bind pewc_host pewc_host_sva #(.BLW_CYC(BLW_CYC), .PROG_CYC(PROG_CYC)) chk_u (
    .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .CMD_VALID_I(CMD_VALID_I),
    .CMD_OP_I(CMD_OP_I), .CMD_READY_O(CMD_READY_O), .RD_VALID_O(RD_VALID_O),
    .DONE_O(DONE_O), .TIMEOUT_O(TIMEOUT_O), .BUSY_O(BUSY_O), .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_CE_N_O(MEM_CE_N_O), .MEM_OE_N_O(MEM_OE_N_O), .MEM_WE_N_O(MEM_WE_N_O),
    .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE_O(MEM_DQ_OE_O)
);

// ==== bench/pewc_dev_model.sv ====
`include "pewc_regs.vh"

// behavioural paged memory with write lock; no clock, pin edges plus a 10 ns timer loop
module pewc_dev_model #(
    parameter int BLW_NS  = 800,
    parameter int PROG_NS = 4000
) (
    // strobes
    input  logic        ce_n_i,
    input  logic        oe_n_i,
    input  logic        we_n_i,
    // address and host data
    input  logic [16:0] addr_i,
    input  logic [7:0]  dq_i,
    input  logic        dq_oe_i,
    // resolved data lines
    output logic [7:0]  bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [0:131071];
    logic [24:0] q [$];
    logic [16:0] a_q = 17'h0;
    logic [7:0]  last_q = 8'h0, ld_q = 8'h0;
    logic        oe_seen = 0, busy = 0, tog = 0, lock = 0, lock_nx = 0;
    time         t_ld = 0, t_end = 0;
    wire         wr_n = ce_n_i | we_n_i;
    wire         drv  = !ce_n_i && !oe_n_i && we_n_i;
    // status byte while programming, array data otherwise
    wire [7:0]   rd_v = busy ? {~ld_q[7], tog, ld_q[5:0]} : mem[addr_i];
    // floating lines show the inverse of the last driven value
    assign bus_o = dq_oe_i ? dq_i : drv ? rd_v : ~last_q;
    always @(bus_o) if (dq_oe_i || drv) last_q = bus_o;
    initial for (int i = 0; i < 131072; i++) mem[i] = 8'hff;

    function automatic bit m(int i, logic [14:0] a, logic [7:0] d);
        return q[i][22:8] == a && q[i][7:0] == d;
    endfunction

    // end the load: decode command words, write the page, start the timer
    task automatic commit();
        bit p, u;
        int s;
        p = q.size() >= 3 && m(0, `PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_1)
            && m(1, `PEWC_CMD_ADDR_2, `PEWC_CMD_DATA_2) && m(2, `PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_PROT);
        u = q.size() >= 6 && m(0, `PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_1)
            && m(1, `PEWC_CMD_ADDR_2, `PEWC_CMD_DATA_2) && m(2, `PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_UNL1)
            && m(3, `PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_1) && m(4, `PEWC_CMD_ADDR_2, `PEWC_CMD_DATA_2)
            && m(5, `PEWC_CMD_ADDR_1, `PEWC_CMD_DATA_UNL2);
        lock_nx = u ? 1'b0 : p ? 1'b1 : lock;
        s = u ? 6 : p ? 3 : lock ? q.size() : 0;
        for (int i = s; i < q.size(); i++) mem[q[i][24:8]] = q[i][7:0];
        ld_q = q[q.size() - 1][7:0];
        q.delete();
        busy = 1'b1;
        t_end = $time + PROG_NS;
    endtask

    // address on the later falling strobe, data on the earlier rising one
    always @(negedge wr_n)
    begin
        a_q = addr_i;
        oe_seen = 1'b0;
    end
    always @(posedge oe_n_i) if (!wr_n) oe_seen = 1'b1;
    always @(posedge wr_n) if (oe_seen && !busy && q.size() < 134)
    begin
        q.push_back({a_q, bus_o});
        t_ld = $time;
    end
    // a read frame ends any load and, while programming, advances the toggle bit
    always @(negedge (ce_n_i | oe_n_i))
    begin
        #1;
        if (we_n_i && !ce_n_i && !oe_n_i && q.size() != 0) commit();
        if (we_n_i && !ce_n_i && !oe_n_i && busy) tog = ~tog;
    end
    // window and program timers; the lock state changes at end of write
    always #10
    begin
        if (q.size() != 0 && ($time - t_ld > BLW_NS || q.size() == 134)) commit();
        if (busy && $time >= t_end) {busy, lock} = {1'b0, lock_nx};
    end
endmodule // pewc_dev_model

// ==== bench/tb_top.sv ====
`include "pewc_regs.vh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_prot = 1'b0, cmd_last = 1'b0;
    logic [1:0]  cmd_op = 2'h0;
    logic [16:0] cmd_addr = 17'h0;
    logic [7:0]  cmd_data = 8'h0;
    wire         cmd_ready, rd_valid, done, tmo, busy, ce_n, oe_n, we_n, dq_oe;
    wire  [7:0]  rd_data, dq_o, bus;
    wire  [16:0] mem_addr;
    int          bad_count = 0, n_checks = 0, cyc = 0;
    always #10 clk = ~clk;

    pewc_host #(.BLW_CYC(20'd40), .PROG_CYC(20'd400)) dut_u (
        .REF_CLK_I(clk), .RESET_N_I(rst_n), .CMD_VALID_I(cmd_valid), .CMD_OP_I(cmd_op),
        .CMD_ADDR_I(cmd_addr), .CMD_DATA_I(cmd_data), .CMD_PROT_I(cmd_prot),
        .CMD_LAST_I(cmd_last), .CMD_READY_O(cmd_ready), .RD_DATA_O(rd_data),
        .RD_VALID_O(rd_valid), .DONE_O(done), .TIMEOUT_O(tmo), .BUSY_O(busy),
        .MEM_ADDR_O(mem_addr), .MEM_CE_N_O(ce_n), .MEM_OE_N_O(oe_n), .MEM_WE_N_O(we_n),
        .MEM_DQ_I(bus), .MEM_DQ_O(dq_o), .MEM_DQ_OE_O(dq_oe)
    );
    pewc_dev_model #(.BLW_NS(800), .PROG_NS(4000)) dev_u (
        .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(mem_addr),
        .dq_i(dq_o), .dq_oe_i(dq_oe), .bus_o(bus)
    );

    task automatic wrap_up();
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(logic [7:0] got, logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // present a command at the falling edge, hold until taken
    task automatic send(logic [1:0] op, logic [16:0] a, logic [7:0] d, logic p, logic l);
        int n;
        @(negedge clk);
        {cmd_valid, cmd_op, cmd_addr, cmd_data, cmd_prot, cmd_last} = {1'b1, op, a, d, p, l};
        n = 0;
        #1;
        while (cmd_ready !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            #1;
            n++;
        end
        if (n == 3000) chk(8'h00, 8'h01);
        @(posedge clk);
    endtask

    // drop the request and wait for the end of programming
    task automatic wait_done();
        int n;
        @(negedge clk) cmd_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            if (tmo === 1'b1) chk(8'h00, 8'h01);
            n++;
        end
        chk({7'h0, done}, 8'h01);
    endtask

    task automatic rd_chk(logic [16:0] a, logic [7:0] e);
        int n;
        send(`PEWC_OP_READ, a, 8'h00, 1'b0, 1'b0);
        @(negedge clk) cmd_valid = 1'b0;
        n = 0;
        while (rd_valid !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        chk({6'h0, busy, rd_valid}, 8'h03);
        chk(rd_data, e);
    endtask

    // single byte: the load window closes it
    task automatic t_window();
        send(`PEWC_OP_WRITE, 17'h00105, 8'h5a, 1'b0, 1'b0);
        wait_done();
        rd_chk(17'h00105, 8'h5a);
    endtask

    // three bytes back to back, then a page change ends the load early
    task automatic t_page();
        for (logic [7:0] i = 0; i < 3; i++)
            send(`PEWC_OP_WRITE, 17'h00180 + i, 8'ha1 + i, 1'b0, i == 2);
        wait_done();
        for (logic [7:0] i = 0; i < 3; i++)
            rd_chk(17'h00180 + i, 8'ha1 + i);
        send(`PEWC_OP_WRITE, 17'h00200, 8'h3c, 1'b0, 1'b0);
        send(`PEWC_OP_WRITE, 17'h00400, 8'hc3, 1'b0, 1'b1);
        wait_done();
        rd_chk(17'h00200, 8'h3c);
        rd_chk(17'h00400, 8'hc3);
    endtask

    // lock on, plain write refused, protected write, lock off
    task automatic t_lock();
        send(`PEWC_OP_LOCK_ON, 17'h0, 8'h00, 1'b0, 1'b0);
        wait_done();
        send(`PEWC_OP_WRITE, 17'h00300, 8'h11, 1'b0, 1'b1);
        wait_done();
        rd_chk(17'h00300, 8'hff);
        send(`PEWC_OP_WRITE, 17'h00300, 8'h22, 1'b1, 1'b1);
        wait_done();
        rd_chk(17'h00300, 8'h22);
        send(`PEWC_OP_LOCK_OFF, 17'h0, 8'h00, 1'b0, 1'b0);
        wait_done();
        send(`PEWC_OP_WRITE, 17'h00300, 8'h33, 1'b0, 1'b1);
        wait_done();
        rd_chk(17'h00300, 8'h33);
    endtask

    // cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_window();
        t_page();
        t_lock();
        wrap_up();
    end
endmodule // tb_top
